// ### hw/smbm_addr_match.sv
// smbm_addr_match: slave side address recognition, hardware acknowledge
// and clock stretching of a two-wire serial port.
// assumes: SCL/SDA arrive asynchronously and are open drain outside;
// a register master on CLK with one-cycle strobes.
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
module smbm_addr_match #(
  parameter int SYNC_DEPTH = 2
) (
  // clock and reset
  input wire logic CLK,
  input wire logic SRST,
  // register port
  input wire smbm_pkg::smbm_req_type REQ,
  output logic [7:0] RDATA,
  // serial clock pin
  input wire logic SCL_IN,
  output logic SCL_OUT,
  output logic SCL_OE,
  // serial data pin
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  // interrupt
  output logic IRQ
);
  import smbm_pkg::*;

  // a single flop cannot settle a metastable pin sample
  generate
    if (SYNC_DEPTH < 2) begin : g_bad_depth
      $error("SYNC_DEPTH must be at least 2");
    end
  endgenerate

  logic [SYNC_DEPTH-1:0] scl_sync;
  logic [SYNC_DEPTH-1:0] sda_sync;
  logic scl_d;
  logic sda_d;
  smbm_state_type state;
  smbm_state_type next_state;
  logic [3:0] bit_cnt;
  logic [3:0] next_cnt;
  logic [7:0] shreg;
  logic is_addr;
  logic next_is_addr;
  logic hw_mode;
  logic next_hw;
  logic ack_drive;
  logic next_drive;
  logic [6:0] slv;
  logic gc;
  logic [6:0] mask;
  logic hw_ack_enable;
  logic si;
  logic ack_bit;
  logic ackrq;
  logic sta;
  logic rw_q;
  logic [EV_W-1:0] stat;
  logic [EV_W-1:0] ien;
  logic [EV_W-1:0] ev;

  // pins: open drain, we only ever pull low
  assign SCL_OUT = 1'b0;
  assign SDA_OUT = 1'b0;

  // SYNC_DEPTH stage synchronisers (two by default); edges are taken after the last stage only
  always_ff @(posedge CLK) begin
    if (SRST) begin
      scl_sync <= '1;
      sda_sync <= '1;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[SYNC_DEPTH-2:0], SCL_IN};
      sda_sync <= {sda_sync[SYNC_DEPTH-2:0], SDA_IN};
      scl_d <= scl_sync[SYNC_DEPTH-1];
      sda_d <= sda_sync[SYNC_DEPTH-1];
    end
  end

  // bus conditions seen on the synchronised lines
  wire scl_s = scl_sync[SYNC_DEPTH-1];
  wire sda_s = sda_sync[SYNC_DEPTH-1];
  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire start_det = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_det = scl_s & scl_d & ~sda_d & sda_s;
  wire bus_cond = start_det | stop_det;

  // register decode
  wire wr_ctrl = REQ.wr && (REQ.addr == ADDR_CTRL);
  wire wr_ien = REQ.wr && (REQ.addr == ADDR_IEN);
  wire wr_slv = REQ.wr && (REQ.addr == ADDR_SLV);
  wire wr_mask = REQ.wr && (REQ.addr == ADDR_MASK);
  wire wr_iclr = REQ.wr && (REQ.addr == ADDR_ICLR);

  // address compare on the seven upper bits of the received byte
  wire addr_hit = smbm_match(shreg[7:1], slv, mask, gc);
  wire byte_done = (state == ST_SHIFT) && scl_fall &&
                   (bit_cnt == BITS_PER_BYTE) && !bus_cond;
  wire ack_end = (state == ST_ACK) && scl_fall && !bus_cond;
  // byte handed to software: manual at the byte, hw after the ack bit
  wire hand_off = (byte_done && !hw_ack_enable) || (ack_end && hw_mode);
  wire si_set = hand_off;
  wire ackrq_set = byte_done && !hw_ack_enable;
  wire ackrq_clr = (state == ST_HOLD) && !si;

  assign ev[EV_ADDR] = hand_off && is_addr;
  assign ev[EV_DATA] = hand_off && !is_addr;
  assign ev[EV_STOP] = stop_det && (state != ST_IDLE);

  // byte state machine; start and stop override any state
  always_comb begin
    next_state = state;
    next_cnt = bit_cnt;
    next_is_addr = is_addr;
    next_hw = hw_mode;
    next_drive = ack_drive;
    if (stop_det) begin
      next_state = ST_IDLE;
      next_drive = 1'b0;
    end else if (start_det) begin
      next_state = ST_SHIFT;
      next_cnt = 4'h0;
      next_is_addr = 1'b1;
      next_drive = 1'b0;
    end else begin
      unique case (state)
        ST_IDLE, ST_SKIP: begin
        end
        ST_SHIFT: begin
          if (scl_rise) begin
            next_cnt = bit_cnt + 4'h1;
          end
          if (byte_done) begin
            next_hw = hw_ack_enable;
            if (hw_ack_enable && is_addr && !addr_hit) begin
              next_state = ST_SKIP;
            end else if (hw_ack_enable) begin
              next_state = ST_ACK;
              next_drive = 1'b1;
            end else begin
              next_state = ST_HOLD;
            end
          end
        end
        ST_HOLD: begin
          if (!si) begin
            next_state = ST_ACK;
            next_drive = ack_bit;
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            next_drive = 1'b0;
            next_cnt = 4'h0;
            next_is_addr = 1'b0;
            // slave transmit is not handled here: a read waits for stop
            next_state = (is_addr && shreg[0]) ? ST_SKIP : ST_SHIFT;
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      is_addr <= 1'b0;
      hw_mode <= 1'b0;
      ack_drive <= 1'b0;
    end else begin
      state <= next_state;
      bit_cnt <= next_cnt;
      is_addr <= next_is_addr;
      hw_mode <= next_hw;
      ack_drive <= next_drive;
    end
  end

  // shift on SCL rise, msb first
  always_ff @(posedge CLK) begin
    if (SRST) begin
      shreg <= 8'h00;
    end else if ((state == ST_SHIFT) && scl_rise && !bus_cond) begin
      shreg <= {shreg[6:0], sda_s};
    end
  end

  // address and mask registers
  always_ff @(posedge CLK) begin
    if (SRST) begin
      {slv, gc} <= SLV_RESET;
      {mask, hw_ack_enable} <= MASK_RESET;
    end else begin
      if (wr_slv) begin
        {slv, gc} <= REQ.wdata;
      end
      if (wr_mask) begin
        {mask, hw_ack_enable} <= REQ.wdata;
      end
    end
  end

  // control flags: hardware set wins over a software clear
  always_ff @(posedge CLK) begin
    if (SRST) begin
      si <= 1'b0;
      ack_bit <= 1'b0;
      ackrq <= 1'b0;
      sta <= 1'b0;
      rw_q <= 1'b0;
    end else begin
      si <= si_set | (wr_ctrl ? REQ.wdata[CTRL_SI] : si);
      sta <= ev[EV_ADDR] | (wr_ctrl ? REQ.wdata[CTRL_STA] : sta);
      ackrq <= ackrq_set | (ackrq & ~ackrq_clr);
      if (wr_ctrl) begin
        ack_bit <= REQ.wdata[CTRL_ACK];
      end
      if (ev[EV_ADDR]) begin
        rw_q <= shreg[0];
      end
    end
  end

  // sticky event bits, one per event
  genvar gi;
  generate
    for (gi = 0; gi < EV_W; gi++) begin : g_stat
      always_ff @(posedge CLK) begin
        if (SRST) begin
          stat[gi] <= 1'b0;
        end else begin
          stat[gi] <= ev[gi] | (stat[gi] & ~(wr_iclr & REQ.wdata[gi]));
        end
      end
    end
  endgenerate

  always_ff @(posedge CLK) begin
    if (SRST) begin
      ien <= '0;
    end else if (wr_ien) begin
      ien <= REQ.wdata[EV_W-1:0];
    end
  end

  // read mux; unmapped and write-only addresses read zero
  wire [7:0] ctrl_word = {3'h0, rw_q, sta, ackrq, ack_bit, si};
  wire [7:0] rd_word =
    (REQ.addr == ADDR_CTRL) ? ctrl_word :
    (REQ.addr == ADDR_DATA) ? shreg :
    (REQ.addr == ADDR_STAT) ? {{(8-EV_W){1'b0}}, stat} :
    (REQ.addr == ADDR_IEN) ? {{(8-EV_W){1'b0}}, ien} :
    (REQ.addr == ADDR_SLV) ? {slv, gc} :
    (REQ.addr == ADDR_MASK) ? {mask, hw_ack_enable} : 8'h00;

  always_ff @(posedge CLK) begin
    if (SRST) begin
      RDATA <= 8'h00;
    end else if (REQ.rd) begin
      RDATA <= rd_word;
    end
  end

  // outputs; stretching SCL through si keeps the master from racing
  // ahead of firmware, at the cost of bus speed
  assign SCL_OE = si;
  assign SDA_OE = ack_drive;
  assign IRQ = |(stat & ien);

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SRST);

  a_scl_stretch: assert property (si |-> SCL_OE)
    else $error("SCL released while flag set");
  a_addr_ack: assert property ((state == ST_ACK) && is_addr && hw_mode
      |-> SDA_OE && smbm_match(shreg[7:1], slv, mask, gc))
    else $error("hw address ack without match");
  a_nomatch_free: assert property (byte_done && hw_ack_enable && is_addr
      && !addr_hit |=> ((state == ST_SKIP) && !SDA_OE) [*2])
    else $error("unmatched address not released");
  a_data_ack: assert property (byte_done && hw_ack_enable && !is_addr
      |=> (state == ST_ACK) && SDA_OE)
    else $error("data byte not auto acked");
  a_manual_hold: assert property (byte_done && !hw_ack_enable
      |=> (state == ST_HOLD) && si && ackrq && !SDA_OE)
    else $error("manual ack not stalled");
  a_manual_ack: assert property ((state == ST_HOLD) && !si && !bus_cond
      |=> (state == ST_ACK) && (SDA_OE == $past(ack_bit)))
    else $error("firmware ack value not driven");
  a_addr_irq: assert property (ack_end && hw_mode && is_addr
      |=> si && sta && stat[EV_ADDR])
    else $error("address event not flagged");
  a_slv_write: assert property (wr_slv
      |=> {slv, gc} == $past(REQ.wdata))
    else $error("address register layout wrong");
  a_slv_read: assert property (REQ.rd && (REQ.addr == ADDR_SLV)
      |=> RDATA == $past({slv, gc}))
    else $error("address register read wrong");
  a_mask_write: assert property (wr_mask
      |=> {mask, hw_ack_enable} == $past(REQ.wdata))
    else $error("mask register layout wrong");
  a_gc_match: assert property (gc == smbm_match(GC_ADDR, 7'h7F,
      7'h7F, gc))
    else $error("general call gating wrong");
  a_ex_mask: assert property (smbm_match(7'h35, 7'h34, 7'h7E, 1'b0)
      && smbm_match(7'h00, 7'h34, 7'h7E, 1'b1)
      && !smbm_match(7'h36, 7'h34, 7'h7E, 1'b0))
    else $error("mask example 0x34/0x7E wrong");
  a_ex_four: assert property (smbm_match(7'h7C, 7'h70, 7'h73, 1'b0)
      && smbm_match(7'h78, 7'h70, 7'h73, 1'b0)
      && !smbm_match(7'h71, 7'h70, 7'h73, 1'b0)
      && !smbm_match(7'h00, 7'h70, 7'h73, 1'b0))
    else $error("mask example 0x70/0x73 wrong");

  c_hw_ack: cover property (byte_done && hw_ack_enable && is_addr && addr_hit);
  c_skip: cover property (byte_done && hw_ack_enable && is_addr && !addr_hit);
  c_manual: cover property ((state == ST_HOLD) ##[1:1000] !si);
  c_stop: cover property (ev[EV_STOP]);
endmodule // smbm_addr_match

// ### hw/smbm_pkg.sv
// smbm_pkg: constants, types and the address compare for the
// slave address recognition block.
// assumes: one system clock, registers on a plain byte-wide port.
package smbm_pkg;
  // register addresses on the byte port
  localparam logic [7:0] ADDR_CTRL = 8'hF0;
  localparam logic [7:0] ADDR_DATA = 8'hF1;
  localparam logic [7:0] ADDR_STAT = 8'hF2;
  localparam logic [7:0] ADDR_IEN = 8'hF3;
  localparam logic [7:0] ADDR_SLV = 8'hF4;
  localparam logic [7:0] ADDR_MASK = 8'hF5;
  localparam logic [7:0] ADDR_ICLR = 8'hF6;
  // reset values
  localparam logic [7:0] SLV_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'hFE;
  // control register bits
  localparam int CTRL_SI = 0;
  localparam int CTRL_ACK = 1;
  localparam int CTRL_ACKRQ = 2;
  localparam int CTRL_STA = 3;
  localparam int CTRL_RW = 4;
  // low bit of both address registers is the enable bit
  localparam int EN_BIT = 0;
  // event bits in status, enable and clear
  localparam int EV_W = 3;
  localparam int EV_ADDR = 0;
  localparam int EV_DATA = 1;
  localparam int EV_STOP = 2;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [6:0] GC_ADDR = 7'h00;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } smbm_req_type;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_SHIFT = 5'b00010,
    ST_HOLD = 5'b00100,
    ST_ACK = 5'b01000,
    ST_SKIP = 5'b10000
  } smbm_state_type;

  // masked compare plus optional general call
  function automatic logic smbm_match(input logic [6:0] a,
      input logic [6:0] slv, input logic [6:0] mask, input logic gc);
    smbm_match = (((a ^ slv) & mask) == 7'h00) ||
                 (gc && (a == GC_ADDR));
  endfunction
endpackage

// ### dv/smbm_master_model.sv
// smbm_master_model: behavioural bus master for the two-wire link.
// assumes: both lines are open drain with pull-ups outside; the line
// levels come back in, so a slave that stretches SCL is waited for.
`timescale 1ns/1ps
module smbm_master_model (
  // line levels
  input wire logic scl,
  input wire logic sda,
  // pull-down enables, high pulls the line low
  output logic scl_low,
  output logic sda_low
);
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end

  // start: SDA falls while SCL stays high
  task automatic start_cond();
    sda_low = 1'b0;
    scl_low = 1'b0;
    #80 sda_low = 1'b1;
    #80 scl_low = 1'b1;
  endtask

  // one 160 ns bit; waits out any stretch before the high phase
  task automatic clock_bit(input logic b, output logic seen);
    sda_low = ~b;
    #40 scl_low = 1'b0;
    wait (scl === 1'b1);
    #40 seen = sda;
    #40 scl_low = 1'b1;
    #40;
  endtask

  // byte out msb first, then the ninth bit with SDA released
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(b[i], s);
    end
    clock_bit(1'b1, s);
    ack = ~s;
  endtask

  // stop: SDA rises while SCL is high
  task automatic stop_cond();
    sda_low = 1'b1;
    #40 scl_low = 1'b0;
    wait (scl === 1'b1);
    #80 sda_low = 1'b0;
    #80;
  endtask
endmodule // smbm_master_model

// ### dv/test_smbm_addr_match.sv
// test_smbm_addr_match: self-checking bench for address recognition.
// assumes: smbm_pkg compiled first; the master model owns the link.
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
  miscompares++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module test_smbm_addr_match;
  import smbm_pkg::*;
  logic CLK = 1'b0;
  logic SRST = 1'b1;
  smbm_req_type req = '0;
  logic [7:0] rdata;
  logic scl_oe, sda_oe, irq, m_scl, m_sda, scl, sda, ien;
  logic scl_out, sda_out;
  int miscompares = 0;
  int num_checks = 0;
  int cyc = 0;

  // wired-and with pull-ups; the output level pins are always 0
  assign scl = !(m_scl || scl_oe);
  assign sda = !(m_sda || sda_oe);

  smbm_addr_match dut_u (.CLK(CLK), .SRST(SRST), .REQ(req),
    .RDATA(rdata), .SCL_IN(scl), .SCL_OUT(scl_out), .SCL_OE(scl_oe),
    .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe), .IRQ(irq));
  smbm_master_model mm (.scl(scl), .sda(sda), .scl_low(m_scl),
    .sda_low(m_sda));

  always #10 CLK = ~CLK;

  // hang guard: frames take one to two hundred cycles each
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 40000) begin
      miscompares++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // register bus: one-cycle strobes, read data the cycle after rd
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge CLK);
    req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge CLK);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge CLK);
    req.rd <= 1'b0;
    #1 d = rdata;
  endtask

  // one addressed write frame under hardware acknowledge
  task automatic frame(input logic [6:0] s, input logic [6:0] m,
      input logic g, input logic [6:0] a, input logic dat);
    logic ack, ex;
    logic [7:0] d;
    ex = (((a ^ s) & m) == 7'h00) || (g && a == 7'h00);
    wr(ADDR_SLV, {s, g});
    wr(ADDR_MASK, {m, 1'b1});
    mm.start_cond();
    mm.send_byte({a, 1'b0}, ack);
    `CHK("addr ack", ex, ack)
    repeat (8) @(posedge CLK);
    #1 `CHK("scl held", ex, scl_oe)
    `CHK("irq", ex & ien, irq)
    if (ex) begin
      rd(ADDR_STAT, d);
      `CHK("stat", 8'h01, d & 8'h01)
      wr(ADDR_ICLR, 8'h01);
      wr(ADDR_CTRL, 8'h00);
      @(posedge CLK);
      #1 `CHK("scl free", 1'b0, scl_oe)
      `CHK("irq clr", 1'b0, irq)
      if (dat) begin
        mm.send_byte(8'hA5, ack);
        `CHK("data ack", 1'b1, ack)
        rd(ADDR_DATA, d);
        `CHK("data", 8'hA5, d)
        wr(ADDR_CTRL, 8'h00);
      end
    end
    mm.stop_cond();
  endtask

  task automatic sc_regs();
    logic [7:0] d;
    rd(ADDR_SLV, d);
    `CHK("slv rst", 8'h00, d)
    rd(ADDR_MASK, d);
    `CHK("mask rst", 8'hFE, d)
    wr(ADDR_SLV, 8'h69);
    wr(ADDR_MASK, 8'h81);
    rd(ADDR_SLV, d);
    `CHK("slv rw", 8'h69, d)
    rd(ADDR_MASK, d);
    `CHK("mask rw", 8'h81, d)
    rd(8'hF9, d);
    `CHK("unmapped", 8'h00, d)
  endtask

  // table cases, near misses and general call both ways
  task automatic sc_match();
    ien = 1'b1;
    wr(ADDR_IEN, 8'h01);
    frame(7'h34, 7'h7E, 1'b0, 7'h34, 1'b1);
    frame(7'h34, 7'h7E, 1'b0, 7'h35, 1'b0);
    frame(7'h34, 7'h7E, 1'b0, 7'h36, 1'b0);
    frame(7'h34, 7'h7E, 1'b0, 7'h00, 1'b0);
    frame(7'h34, 7'h7E, 1'b1, 7'h00, 1'b1);
    frame(7'h34, 7'h7F, 1'b0, 7'h35, 1'b0);
    for (int i = 0; i < 8; i++) begin
      frame(7'h70, 7'h73, 1'b0, 7'h70 + i, 1'b0);
    end
    frame(7'h70, 7'h73, 1'b0, 7'h78, 1'b0);
    frame(7'h70, 7'h73, 1'b0, 7'h7C, 1'b0);
    ien = 1'b0;
    wr(ADDR_IEN, 8'h00);
    frame(7'h34, 7'h7F, 1'b0, 7'h34, 1'b0);
  endtask

  // software answers the stall with the given ack value
  task automatic sw_ack(input logic v);
    int n;
    n = 0;
    while (scl_oe !== 1'b1 && n < 500) begin
      @(posedge CLK);
      n++;
    end
    `CHK("stall", 1'b1, scl_oe)
    wr(ADDR_CTRL, {6'h00, v, 1'b0});
  endtask

  task automatic sc_manual();
    logic ack;
    wr(ADDR_MASK, 8'hFE);
    mm.start_cond();
    fork
      mm.send_byte(8'h22, ack);
      sw_ack(1'b1);
    join
    `CHK("fw ack", 1'b1, ack)
    fork
      mm.send_byte(8'h3C, ack);
      sw_ack(1'b0);
    join
    `CHK("fw nack", 1'b0, ack)
    mm.stop_cond();
  endtask

  initial begin
    ien = 1'b0;
    repeat (16) @(posedge CLK);
    SRST <= 1'b0;
    #1 `CHK("irq rst", 1'b0, irq)
    `CHK("scl out", 1'b0, scl_out)
    `CHK("sda out", 1'b0, sda_out)
    sc_regs();
    sc_match();
    sc_manual();
    close_out();
  end
endmodule // test_smbm_addr_match
